/* hw/tsc_defines.svh */
/*
  register map, field positions, reset values and timing counts of the tuner
  configuration bank. assumes a 250 MHz core clock and 32-bit APB data.
*/
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

// ---------------------------------------------------------------------------
// register indices and byte addresses
// ---------------------------------------------------------------------------
`define TSC_CFG1_IDX 12'h004
`define TSC_CFG2_IDX 12'h005
`define TSC_CFG1_ADDR (`TSC_CFG1_IDX << 2)
`define TSC_CFG2_ADDR (`TSC_CFG2_IDX << 2)
`define TSC_EXT_ADDR 12'h018
`define TSC_STAT_ADDR 12'h01c
`define TSC_CLR_ADDR 12'h020
`define TSC_IEN_ADDR 12'h024
`define TSC_LIVE_ADDR 12'h028

// ---------------------------------------------------------------------------
// reset values and writable masks
// ---------------------------------------------------------------------------
`define TSC_CFG1_RST 16'h0000
`define TSC_CFG2_RST 16'h0000
`define TSC_CFG1_WMASK 16'hdcff
`define TSC_EV_RST 3'h0

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define TSC_RDS_IEN_BIT 15
`define TSC_TUNE_IEN_BIT 14
`define TSC_RDS_EN_BIT 12
`define TSC_DEEMPH_BIT 11
`define TSC_AGC_OFF_BIT 10
`define TSC_BLEND_LSB 6
`define TSC_PIN1_LSB 0
`define TSC_SEEK_LSB 8
`define TSC_BAND_LSB 6
`define TSC_SPACE_LSB 4
`define TSC_VOL_LSB 0

// ---------------------------------------------------------------------------
// analog figures and timing
// ---------------------------------------------------------------------------
`define TSC_DEEMPH_SLOW_US 7'h4b
`define TSC_DEEMPH_FAST_US 7'h32
`define TSC_BLEND_LO_0 8'h1f
`define TSC_BLEND_LO_1 8'h25
`define TSC_BLEND_LO_2 8'h13
`define TSC_BLEND_LO_3 8'h19
`define TSC_BASE_WIDE_KHZ 19'h155cc
`define TSC_BASE_LOW_KHZ 19'h128e0
`define TSC_SPACE_200_KHZ 8'hc8
`define TSC_SPACE_100_KHZ 8'h64
`define TSC_SPACE_50_KHZ 8'h32
`define TSC_EXT_ATTEN_DB 6'h1e
`define TSC_PULSE_MS 5
`define TSC_CLK_KHZ 250000
`define TSC_PULSE_CYCLES (`TSC_PULSE_MS * `TSC_CLK_KHZ)

`endif

/* hw/tsc_pkg.sv */
/*
  shared types of the tuner configuration bank.
  assumes nothing beyond a SystemVerilog compiler.
*/
package tsc_pkg;
  // pin drive codes
  typedef enum logic [1:0] {
    PIN_HIZ = 2'h0,
    PIN_SPECIAL = 2'h1,
    PIN_LOW = 2'h2,
    PIN_HIGH = 2'h3
  } tsc_pin_mode_t;

  // interrupt pulse sequencer
  typedef enum logic {
    PS_IDLE,
    PS_LOW
  } tsc_pulse_state_t;
endpackage

/* hw/tsc_pulse_if.sv */
/*
  carrier between the register bank and its interrupt pulse generator.
  assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface tsc_pulse_if;
  logic trig;
  logic busy;

  modport ctrl (output trig, input busy);
  modport gen (input trig, output busy);
endinterface

/* hw/tsc_pulse_gen.sv */
/*
  one-shot low-pulse timer for the interrupt pin.
  assumes trig is a one-cycle pulse synchronous to CLOCK.
*/
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_pulse_gen
  import tsc_pkg::*;
#(
  parameter int PULSE_CYCLES = `TSC_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control side
  tsc_pulse_if.gen pif
);
  localparam int CW = $clog2(PULSE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(PULSE_CYCLES - 1);

  tsc_pulse_state_t state;
  logic [CW-1:0] cnt;
  wire cnt_done = (cnt == LAST);

  // elaboration guard
  generate
    if (PULSE_CYCLES < 1) begin : g_bad_len
      $error("pulse length must be at least one cycle");
    end
  endgenerate

  // a new event restarts the pulse so no event is swallowed silently
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= PS_IDLE;
      cnt <= '0;
    end else begin
      case (state)
        PS_IDLE: begin
          if (pif.trig) begin
            state <= PS_LOW;
            cnt <= '0;
          end
        end
        PS_LOW: begin
          if (pif.trig) begin
            cnt <= '0;
          end else if (cnt_done) begin
            state <= PS_IDLE;
          end else begin
            cnt <= cnt + CW'(1);
          end
        end
        default: state <= PS_IDLE;
      endcase
    end
  end

  assign pif.busy = (state == PS_LOW);

  chk_pulse_full_len: assert property (@(posedge clk) disable iff (rst)
    $fell(pif.busy) |-> $past(cnt) == LAST)
    else $error("interrupt pulse ended at wrong length");
endmodule

/* hw/tsc_cfg_regs.sv */
/*
  tuner system configuration bank: two configuration words behind APB,
  their pin, blend, seek, band, spacing and volume decode, and the
  interrupt pulse on pin 2.
  assumes event and signal-strength inputs are synchronous to CLOCK and
  that the pin pads resolve the level from the output enables.
*/
// The APB slave port was left to the implementer.
// Overview of operation
// - rds ready rise pulses pin2 low 5ms
// - tune done rise pulses pin2 low 5ms
// - interrupt mode holds pin2 high otherwise
// - pin codes: 00 hiz, 10 low, 11 high
// - pin3 code 01 shows stereo indicator
// - deemphasis 0 gives 75us, 1 gives 50us
// - gain control runs unless disable bit set
// - blend field selects signal-strength window
// - stereo flag when strength above window floor
// - seek rejects channels below threshold
// - band codes select base, 11 reserved
// - spacing codes give 200, 100, 50 kHz
// - volume 0 mutes, else log steps
// - extended range subtracts 30 dB more
// - frequency is spacing times channel plus base
// - tune completion sets tune done flag
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_cfg_regs
  import tsc_pkg::*;
#(
  parameter int PULSE_CYCLES = `TSC_PULSE_CYCLES
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // receiver events and measurements
  input wire logic RDS_GROUP_READY,
  input wire logic RDS_FLAG_CLEAR,
  input wire logic TUNE_COMPLETE,
  input wire logic TUNE_FLAG_CLEAR,
  input wire logic [7:0] SIGNAL_RSSI,
  input wire logic [9:0] TUNE_CHANNEL,
  // receiver controls
  output logic RDS_DECODE_EN,
  output logic [6:0] DEEMPH_TC_US,
  output logic GAIN_CTRL_ON,
  output logic [7:0] BLEND_LOW_DBUV,
  output logic STEREO_FLAG,
  output logic SEEK_CHAN_VALID,
  output logic [18:0] TUNED_FREQ_KHZ,
  output logic AUDIO_MUTE,
  output logic [5:0] AUDIO_ATTEN_DB,
  // general purpose pins
  input wire logic [2:0] PIN_IN,
  output logic [2:0] PIN_OUT,
  output logic [2:0] PIN_OE,
  // interrupt
  output logic IRQ
);
  // ---------------------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------------------
  logic [15:0] system_config_one;
  logic [15:0] system_config_two;
  logic gain_range_ext;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic rds_ready_flag;
  logic tune_done_flag;
  logic rds_prev;
  logic tune_prev;
  logic stereo_prev;
  logic [18:0] freq_calc;

  tsc_pulse_if pif();

  tsc_pulse_gen #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse (
    .clk(CLOCK),
    .rst(RST),
    .pif(pif)
  );

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  wire setup = PSEL && !PENABLE;
  wire wr_fire = PSEL && PENABLE && PWRITE;
  wire hit_cfg1 = (PADDR == `TSC_CFG1_ADDR);
  wire hit_cfg2 = (PADDR == `TSC_CFG2_ADDR);
  wire hit_ext = (PADDR == `TSC_EXT_ADDR);
  wire hit_stat = (PADDR == `TSC_STAT_ADDR);
  wire hit_clr = (PADDR == `TSC_CLR_ADDR);
  wire hit_ien = (PADDR == `TSC_IEN_ADDR);
  wire hit_live = (PADDR == `TSC_LIVE_ADDR);
  wire mapped = hit_cfg1 | hit_cfg2 | hit_ext | hit_stat | hit_clr | hit_ien | hit_live;
  wire [2:0] clr_req = (wr_fire && hit_clr) ? PWDATA[2:0] : 3'h0;

  // zero-wait slave; unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // read mux, sampled in the setup cycle so read data leave a flip-flop
  wire [31:0] next_rdata =
    hit_cfg1 ? {16'h0000, system_config_one} :
    hit_cfg2 ? {16'h0000, system_config_two} :
    hit_ext ? {31'h00000000, gain_range_ext} :
    hit_stat ? {29'h00000000, irq_status} :
    hit_ien ? {29'h00000000, irq_enable} :
    hit_live ? {28'h0000000, pif.busy, STEREO_FLAG, tune_done_flag, rds_ready_flag} :
    32'h00000000;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (setup) begin
      PRDATA <= next_rdata;
    end
  end

  // reserved bits are masked so they always read zero
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      system_config_one <= `TSC_CFG1_RST;
      system_config_two <= `TSC_CFG2_RST;
      gain_range_ext <= 1'b0;
      irq_enable <= `TSC_EV_RST;
    end else if (wr_fire) begin
      if (hit_cfg1) system_config_one <= PWDATA[15:0] & `TSC_CFG1_WMASK;
      if (hit_cfg2) system_config_two <= PWDATA[15:0];
      if (hit_ext) gain_range_ext <= PWDATA[0];
      if (hit_ien) irq_enable <= PWDATA[2:0];
    end
  end

  // ---------------------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------------------
  wire rds_ready_irq_en = system_config_one[`TSC_RDS_IEN_BIT];
  wire tune_done_irq_en = system_config_one[`TSC_TUNE_IEN_BIT];
  wire rds_en = system_config_one[`TSC_RDS_EN_BIT];
  wire deemph_sel = system_config_one[`TSC_DEEMPH_BIT];
  wire gain_ctrl_off = system_config_one[`TSC_AGC_OFF_BIT];
  wire [1:0] blend_window_sel = system_config_one[`TSC_BLEND_LSB +: 2];
  wire [7:0] seek_level_min = system_config_two[`TSC_SEEK_LSB +: 8];
  wire [1:0] band_sel = system_config_two[`TSC_BAND_LSB +: 2];
  wire [1:0] space_sel = system_config_two[`TSC_SPACE_LSB +: 2];
  wire [3:0] volume = system_config_two[`TSC_VOL_LSB +: 4];
  wire [5:0] pin_modes = system_config_one[`TSC_PIN1_LSB +: 6];
  wire pin2_irq_mode = (tsc_pin_mode_t'(pin_modes[3:2]) == PIN_SPECIAL);

  // blend window floor per code
  wire [7:0] blend_low =
    (blend_window_sel == 2'h0) ? `TSC_BLEND_LO_0 :
    (blend_window_sel == 2'h1) ? `TSC_BLEND_LO_1 :
    (blend_window_sel == 2'h2) ? `TSC_BLEND_LO_2 : `TSC_BLEND_LO_3;
  wire stereo_now = SIGNAL_RSSI > blend_low;

  // code 11 of spacing is undefined; it falls back to the finest step
  wire [7:0] space_khz =
    (space_sel == 2'h0) ? `TSC_SPACE_200_KHZ :
    (space_sel == 2'h1) ? `TSC_SPACE_100_KHZ : `TSC_SPACE_50_KHZ;
  wire [18:0] band_base = (band_sel == 2'h0) ? `TSC_BASE_WIDE_KHZ
                                             : `TSC_BASE_LOW_KHZ;
  wire [18:0] next_freq = 19'(space_khz) * 19'(TUNE_CHANNEL) + band_base;

  // 2 dB per code step: code 1 is 28 dB down, code 15 is 0 dB
  wire [5:0] base_atten = 6'h1e - {1'b0, volume, 1'b0};
  wire [5:0] next_atten = gain_range_ext ? base_atten + `TSC_EXT_ATTEN_DB
                                         : base_atten;
  wire next_mute = (volume == 4'h0);

  // ---------------------------------------------------------------------------
  // flags and interrupt pulse
  // ---------------------------------------------------------------------------
  // set wins over clear so a completion in the clear cycle is kept
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rds_ready_flag <= 1'b0;
      tune_done_flag <= 1'b0;
    end else begin
      if (rds_en && RDS_GROUP_READY) rds_ready_flag <= 1'b1;
      else if (RDS_FLAG_CLEAR) rds_ready_flag <= 1'b0;
      if (TUNE_COMPLETE) tune_done_flag <= 1'b1;
      else if (TUNE_FLAG_CLEAR) tune_done_flag <= 1'b0;
    end
  end

  // edge history for rising-flag and stereo-change detection
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rds_prev <= 1'b0;
      tune_prev <= 1'b0;
      stereo_prev <= 1'b0;
    end else begin
      rds_prev <= rds_ready_flag;
      tune_prev <= tune_done_flag;
      stereo_prev <= STEREO_FLAG;
    end
  end

  wire rds_rise = rds_ready_flag && !rds_prev;
  wire tune_rise = tune_done_flag && !tune_prev;
  wire stereo_chg = STEREO_FLAG != stereo_prev;
  assign pif.trig = pin2_irq_mode &&
    ((rds_rise && rds_ready_irq_en) || (tune_rise && tune_done_irq_en));

  // sticky status, set has priority over a clear in the same cycle
  wire [2:0] events = {stereo_chg, tune_rise, rds_rise};
  wire [2:0] next_status = (irq_status & ~clr_req) | events;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      irq_status <= `TSC_EV_RST;
    end else begin
      irq_status <= next_status;
    end
  end

  assign IRQ = |(irq_status & irq_enable);

  // ---------------------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------------------
  // special function per pin: pin1 has none, pin2 interrupt, pin3 stereo
  wire [2:0] special_val = {STEREO_FLAG, !pif.busy, 1'b0};
  wire [2:0] special_ok = 3'h6; // pin1 code 01 stays floating
  logic [2:0] next_pin_out;
  logic [2:0] next_pin_oe;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      wire [1:0] m = pin_modes[2*gi +: 2];
      assign next_pin_oe[gi] = (m == PIN_LOW) || (m == PIN_HIGH) ||
                               ((m == PIN_SPECIAL) && special_ok[gi]);
      assign next_pin_out[gi] = (m == PIN_HIGH) ||
                                ((m == PIN_SPECIAL) && special_val[gi]);
    end
  endgenerate

  // registered outputs; each lands one cycle after its inputs, so pin2 and pin3 trail pif.trig and SIGNAL_RSSI by two
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PIN_OUT <= 3'h0;
      PIN_OE <= 3'h0;
      STEREO_FLAG <= 1'b0;
      SEEK_CHAN_VALID <= 1'b0;
      freq_calc <= `TSC_BASE_WIDE_KHZ;
      AUDIO_MUTE <= 1'b1;
      AUDIO_ATTEN_DB <= 6'h00;
    end else begin
      PIN_OUT <= next_pin_out;
      PIN_OE <= next_pin_oe;
      STEREO_FLAG <= stereo_now;
      SEEK_CHAN_VALID <= SIGNAL_RSSI >= seek_level_min;
      freq_calc <= next_freq;
      AUDIO_MUTE <= next_mute;
      AUDIO_ATTEN_DB <= next_mute ? 6'h00 : next_atten;
    end
  end

  // static controls follow the configuration word directly; TUNED_FREQ_KHZ follows the registered freq_calc
  assign TUNED_FREQ_KHZ = freq_calc;
  assign RDS_DECODE_EN = rds_en;
  assign DEEMPH_TC_US = deemph_sel ? `TSC_DEEMPH_FAST_US : `TSC_DEEMPH_SLOW_US;
  assign GAIN_CTRL_ON = !gain_ctrl_off;
  assign BLEND_LOW_DBUV = blend_low;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  chk_rds_pulse_start: assert property (@(posedge CLOCK) disable iff (RST)
    rds_rise && rds_ready_irq_en && pin2_irq_mode |=> ##1 PIN_OE[1] && !PIN_OUT[1])
    else $error("rds event gave no low pulse on pin2");
  chk_tune_pulse_start: assert property (@(posedge CLOCK) disable iff (RST)
    TUNE_COMPLETE && !tune_done_flag && tune_done_irq_en && pin2_irq_mode
      ##1 pin2_irq_mode [*2] |=> !PIN_OUT[1])
    else $error("tune completion gave no low pulse on pin2");
  chk_pin2_idle_high: assert property (@(posedge CLOCK) disable iff (RST)
    pin2_irq_mode && !pif.busy |=> PIN_OE[1] && PIN_OUT[1])
    else $error("pin2 not high outside an interrupt pulse");
  chk_pin_fixed_codes: assert property (@(posedge CLOCK) disable iff (RST)
    pin_modes[1:0] == 2'h2 |=> PIN_OE[0] && !PIN_OUT[0])
    else $error("pin1 low code not driving low");
  chk_pin_hiz_code: assert property (@(posedge CLOCK) disable iff (RST)
    pin_modes[5:4] == 2'h0 |=> !PIN_OE[2])
    else $error("pin3 driven in high impedance code");
  chk_stereo_pin: assert property (@(posedge CLOCK) disable iff (RST)
    pin_modes[5:4] == 2'h1 ##1 pin_modes[5:4] == 2'h1 |=> PIN_OUT[2] == $past(STEREO_FLAG))
    else $error("pin3 not following stereo indicator");
  chk_deemph_sel: assert property (@(posedge CLOCK) disable iff (RST)
    DEEMPH_TC_US == (deemph_sel ? 7'h32 : 7'h4b))
    else $error("de-emphasis time constant wrong");
  chk_agc_off: assert property (@(posedge CLOCK) disable iff (RST)
    GAIN_CTRL_ON != system_config_one[10])
    else $error("gain control state does not match disable bit");
  chk_stereo_floor: assert property (@(posedge CLOCK) disable iff (RST)
    blend_window_sel == 2'h2 && SIGNAL_RSSI == 8'h14 |=> STEREO_FLAG)
    else $error("stereo flag not set above window floor");
  chk_seek_reject: assert property (@(posedge CLOCK) disable iff (RST)
    SIGNAL_RSSI < system_config_two[15:8] |=> !SEEK_CHAN_VALID)
    else $error("weak channel accepted by seek");
  chk_band_freq: assert property (@(posedge CLOCK) disable iff (RST)
    band_sel == 2'h1 && space_sel == 2'h1 && TUNE_CHANNEL == 10'h00a
      |=> TUNED_FREQ_KHZ == 19'h12cc8)
    else $error("tuned frequency wrong for band 01 at 100 kHz");
  chk_volume_ext: assert property (@(posedge CLOCK) disable iff (RST)
    gain_range_ext && volume == 4'hf |=> AUDIO_ATTEN_DB == 6'h1e && !AUDIO_MUTE)
    else $error("extended volume range offset wrong");
  chk_volume_mute: assert property (@(posedge CLOCK) disable iff (RST)
    volume == 4'h0 |=> AUDIO_MUTE && AUDIO_ATTEN_DB == 6'h00)
    else $error("volume zero did not mute");
  chk_rds_gate: assert property (@(posedge CLOCK) disable iff (RST)
    !rds_en && !rds_ready_flag |=> !rds_ready_flag)
    else $error("rds flag set while rds disabled");

  // set side of the flags and the remaining decode corners
  chk_tune_flag_set: assert property (@(posedge CLOCK) disable iff (RST)
    TUNE_COMPLETE |=> tune_done_flag)
    else $error("tune completion did not set the flag");
  chk_rds_flag_set: assert property (@(posedge CLOCK) disable iff (RST)
    rds_en && RDS_GROUP_READY |=> rds_ready_flag)
    else $error("rds group did not set the flag while enabled");
  chk_seek_accept: assert property (@(posedge CLOCK) disable iff (RST)
    SIGNAL_RSSI >= system_config_two[15:8] |=> SEEK_CHAN_VALID)
    else $error("strong channel rejected by seek");
  chk_pin_high_code: assert property (@(posedge CLOCK) disable iff (RST)
    pin_modes[5:4] == 2'h3 |=> PIN_OE[2] && PIN_OUT[2])
    else $error("pin3 high code not driving high");
  chk_stereo_below: assert property (@(posedge CLOCK) disable iff (RST)
    SIGNAL_RSSI <= blend_low |=> !STEREO_FLAG)
    else $error("stereo flag set at or below window floor");
  chk_band_base: assert property (@(posedge CLOCK) disable iff (RST)
    band_sel == 2'h0 && TUNE_CHANNEL == 10'h000 |=> TUNED_FREQ_KHZ == 19'h155cc)
    else $error("tuned frequency wrong at channel zero of band 00");
endmodule

/* tb/tsc_host_model.sv */
/*
  host controller model: issues apb transfers to the configuration bank.
  assumes a zero-or-more wait slave and one shared clock.
*/
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_host_model
  import tsc_pkg::*;
(
  // clock
  input wire logic clk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  // idle cycles before each setup, so the host can be prompt or slow
  int gap = 0;

  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // ---------------------------------------------------------------------------
  // one transfer: setup, then access held until pready is seen high
  // ---------------------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    logic [31:0] v;
    v = d & 32'h0000ffff; // upper half of every register is unused
    // a careful host keeps reserved bits clear and skips pin1 code 01
    if (a == `TSC_CFG1_ADDR) begin
      v = v & {16'h0, `TSC_CFG1_WMASK};
      if (v[1:0] == 2'h1) v[1:0] = 2'h0;
    end
    repeat (gap) @(posedge clk);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* tb/test_tuner_system_config_regs.sv */
/*
  self-checking bench of the tuner configuration bank.
  assumes the host model above and a short interrupt pulse parameter.
*/
`timescale 1ns/1ps
`include "tsc_defines.svh"
module test_tuner_system_config_regs
  import tsc_pkg::*;
;
  localparam int PULSE = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic rds_rdy = 1'b0, rds_clr = 1'b0, tune_cmp = 1'b0, tune_clr = 1'b0;
  logic [7:0] rssi = 8'h00;
  logic [9:0] chan = 10'h000;
  logic [2:0] pin_in = 3'h0;
  wire logic psel, penable, pwrite, pready, pslverr;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  wire logic rds_en, gain_on, stereo, seek_valid, mute, irq;
  wire logic [6:0] deemph;
  wire logic [7:0] blend_low;
  wire logic [18:0] freq;
  wire logic [5:0] atten;
  wire logic [2:0] pin_out, pin_oe;
  int fails = 0, total_checks = 0, n, sp, base;
  logic [32:0] expq[$];
  logic [31:0] seed = 32'h1c59a36c, r, v, q;
  logic [7:0] fl;
  logic ext;
  logic [1:0] pcode [3] = '{2'h0, 2'h2, 2'h3};
  logic [7:0] blend_tab [4] = '{8'h1f, 8'h25, 8'h13, 8'h19};

  always #2 clock = ~clock;

  tsc_host_model u_host (.clk(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

  tsc_cfg_regs #(.PULSE_CYCLES(PULSE)) u_dut (.CLOCK(clock), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RDS_GROUP_READY(rds_rdy), .RDS_FLAG_CLEAR(rds_clr),
    .TUNE_COMPLETE(tune_cmp), .TUNE_FLAG_CLEAR(tune_clr), .SIGNAL_RSSI(rssi),
    .TUNE_CHANNEL(chan), .RDS_DECODE_EN(rds_en), .DEEMPH_TC_US(deemph),
    .GAIN_CTRL_ON(gain_on), .BLEND_LOW_DBUV(blend_low), .STEREO_FLAG(stereo),
    .SEEK_CHAN_VALID(seek_valid), .TUNED_FREQ_KHZ(freq), .AUDIO_MUTE(mute),
    .AUDIO_ATTEN_DB(atten), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .IRQ(irq));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected read result is queued before the transfer starts
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask

  // registered outputs need up to two edges; sample away from the edge
  task automatic settle();
    repeat (2) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic fire(input logic rds);
    @(posedge clock);
    if (rds) rds_rdy <= 1'b1;
    else tune_cmp <= 1'b1;
    @(posedge clock);
    rds_rdy <= 1'b0;
    tune_cmp <= 1'b0;
  endtask

  // low time of pin 2, zero when no pulse starts within 20 cycles
  task automatic pulse_len(output int len);
    int w;
    len = 0;
    w = 0;
    while (pin_out[1] !== 1'b0 && w < 20) begin
      @(negedge clock);
      w++;
    end
    while (pin_out[1] === 1'b0 && len < 100) begin
      @(negedge clock);
      len++;
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // read monitor: every completed read is matched with the oldest note
  always @(posedge clock) begin
    logic [32:0] e;
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      e = expq.pop_front();
      cmp(32'(pslverr), 32'(e[32]));
      cmp(prdata, e[31:0]);
    end
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    wrap_up();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(`TSC_CFG1_ADDR, 33'h0);
    rd(`TSC_CFG2_ADDR, 33'h0);
    rd(12'h0fc, {1'b1, 32'h0});
    @(negedge clock);
    cmp(32'(pin_oe), 32'h0);
    cmp(32'(mute), 32'h1);
    cmp(32'(deemph), 32'h4b);
    cmp(32'(gain_on), 32'h1);
    cmp(32'(freq), 32'h155cc);
    u_host.gap = 3;
    wr(`TSC_CFG1_ADDR, 32'h1c00);
    settle();
    cmp(32'(deemph), 32'h32);
    cmp(32'(gain_on), 32'h0);
    cmp(32'(rds_en), 32'h1);
    u_host.gap = 0;
    // drive codes on all three pins at once
    foreach (pcode[i]) begin
      v = 32'(pcode[i]) * 32'h15;
      wr(`TSC_CFG1_ADDR, v);
      settle();
      cmp(32'(pin_oe), (i == 0) ? 32'h0 : 32'h7);
      if (i != 0) cmp(32'(pin_out), (i == 2) ? 32'h7 : 32'h0);
    end
    // blend windows, stereo flag just above and at the floor, pin3 indicator
    for (int b = 0; b < 4; b++) begin
      fl = blend_tab[b];
      wr(`TSC_CFG1_ADDR, (b << 6) | 32'h10);
      settle();
      cmp(32'(blend_low), 32'(fl));
      for (int k = 1; k >= 0; k--) begin
        @(posedge clock);
        rssi <= fl + 8'(k);
        settle();
        cmp(32'(stereo), 32'(k));
        cmp(32'({pin_oe[2], pin_out[2]}), 32'(2 + k));
      end
    end
    // random seek threshold, band, spacing, volume and range
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      v = {16'h0, r[15:8], 2'(r[7:6] % 2'h3), 2'(r[5:4] % 2'h3), r[3:0]};
      ext = r[16];
      wr(`TSC_EXT_ADDR, 32'(ext));
      wr(`TSC_CFG2_ADDR, v);
      r = rnd();
      @(posedge clock);
      rssi <= r[7:0];
      chan <= r[17:8];
      pin_in <= r[20:18];
      settle();
      sp = 200 >> v[5:4];
      base = (v[7:6] == 2'h0) ? 87500 : 76000;
      cmp(32'(seek_valid), 32'(r[7:0] >= v[15:8]));
      cmp(32'(freq), 32'(base + sp * r[17:8]));
      cmp(32'(mute), 32'(v[3:0] == 4'h0));
      cmp(32'(atten), (v[3:0] == 4'h0) ? 32'h0 : 32'(30 - 2 * v[3:0] + (ext ? 30 : 0)));
      rd(`TSC_CFG2_ADDR, {1'b0, v});
    end
    // band 01 at 100 kHz spacing, channel 10
    wr(`TSC_CFG2_ADDR, 32'h0050);
    @(posedge clock);
    chan <= 10'h00a;
    settle();
    cmp(32'(freq), 32'(76000 + 100 * 10));
    // tune done interrupt: pulse, masked, enabled, cleared
    wr(`TSC_CFG1_ADDR, 32'h4004);
    wr(`TSC_IEN_ADDR, 32'h0);
    settle();
    wr(`TSC_CLR_ADDR, 32'h7);
    settle();
    cmp(32'({pin_oe[1], pin_out[1]}), 32'h3);
    fire(1'b0);
    pulse_len(n);
    cmp(32'(n), 32'(PULSE));
    cmp(32'(irq), 32'h0);
    rd(`TSC_STAT_ADDR, 33'h2);
    wr(`TSC_IEN_ADDR, 32'h2);
    @(negedge clock);
    cmp(32'(irq), 32'h1);
    wr(`TSC_CLR_ADDR, 32'h2);
    @(negedge clock);
    cmp(32'(irq), 32'h0);
    @(posedge clock);
    tune_clr <= 1'b1;
    @(posedge clock);
    tune_clr <= 1'b0;
    // rds events are ignored until decoding is switched on
    wr(`TSC_CFG1_ADDR, 32'h8004);
    fire(1'b1);
    pulse_len(n);
    cmp(32'(n), 32'h0);
    wr(`TSC_CFG1_ADDR, 32'h9004);
    fire(1'b1);
    pulse_len(n);
    cmp(32'(n), 32'(PULSE));
    @(posedge clock);
    rds_clr <= 1'b1;
    @(posedge clock);
    rds_clr <= 1'b0;
    settle();
    wrap_up();
  end
endmodule
